/* design/hbs_regs.svh */
// Constants for the hub boot strap sequencer
`ifndef HBS_REGS_SVH
`define HBS_REGS_SVH
`define HBS_SIG_ADDR 16'hfffa
`define HBS_EXEC_ADDR 16'h0000
`define HBS_SIG_WORD 32'h32444655
`define HBS_SIG_LAST 2'h3
`define HBS_SOC_END_REG 8'hff
`define HBS_R200K_PD 3'h0
`define HBS_R200K_PU 3'h1
`define HBS_R10K_PD 3'h2
`define HBS_R10K_PU 3'h3
`define HBS_R10_PD 3'h4
`define HBS_R10_PU 3'h5
`define HBS_STBY_OFF 6'h3f
`define HBS_DEF_OFF 6'h00
`define HBS_DEF_FIXED 6'h00
`define HBS_DEF_CHARGE 6'h00
`define HBS_SPI_WAIT_NS 2560
`define HBS_CLK_NS 10
`endif

/* design/hbs_pkg.sv */
// Types for the hub boot strap sequencer
package hbs_pkg;
	typedef enum logic [2:0] {
		HBS_INIT = 3'b000,
		HBS_SPI_RD = 3'b001,
		HBS_CFG_RD = 3'b010,
		HBS_STRAP = 3'b011,
		HBS_SOC_CFG = 3'b100,
		HBS_OTP_CFG = 3'b101,
		HBS_EXT_RUN = 3'b110
	} hbs_stage_t;
	typedef enum logic [2:0] {
		HBS_GP_IN = 3'b000,
		HBS_GP_IN_PD = 3'b001,
		HBS_GP_IN_PU = 3'b010,
		HBS_GP_OUT_LO = 3'b011,
		HBS_GP_OUT_HI = 3'b100
	} hbs_gpio_mode_t;
endpackage : hbs_pkg

/* design/hbs_strap_decode.sv */
// Strap decoder: line disables and resistor-coded port masks
`timescale 1ns/10ps
`include "hbs_regs.svh"
module hbs_strap_decode (
	input wire logic [5:0] pos_strap,
	input wire logic [5:0] neg_strap,
	input wire logic [2:0] fixed_code,
	input wire logic [2:0] charge_code,
	output logic [5:0] pos_off,
	output logic [5:0] neg_off,
	output logic [5:0] port_off,
	output logic [5:0] ss_off,
	output logic [5:0] fixed_mask,
	output logic [5:0] charge_mask
);
	// Port 5 alone is never selectable; codes past the table give no ports
	function automatic logic [5:0] code_to_mask(input logic [2:0] code);
		case (code)
			`HBS_R200K_PD: code_to_mask = 6'h00;
			`HBS_R200K_PU: code_to_mask = 6'h01;
			`HBS_R10K_PD: code_to_mask = 6'h03;
			`HBS_R10K_PU: code_to_mask = 6'h07;
			`HBS_R10_PD: code_to_mask = 6'h0f;
			`HBS_R10_PU: code_to_mask = 6'h3f;
			default: code_to_mask = 6'h00;
		endcase
	endfunction : code_to_mask

	always_comb begin
		pos_off = pos_strap;
		neg_off = neg_strap;
		port_off = pos_strap & neg_strap;
		ss_off = pos_strap & neg_strap;
		fixed_mask = code_to_mask(fixed_code);
		charge_mask = code_to_mask(charge_code);
	end
endmodule : hbs_strap_decode

/* design/hbs_gpio.sv */
// General-purpose pin mode storage with two write ports
`timescale 1ns/10ps
module hbs_gpio #(
	parameter int NGPIO = 8,
	parameter int IW = 3
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic smb_en,
	input wire logic smb_wr,
	input wire logic [IW-1:0] smb_idx,
	input wire logic [2:0] smb_mode,
	input wire logic usb_wr,
	input wire logic [IW-1:0] usb_idx,
	input wire logic [2:0] usb_mode,
	output logic [NGPIO-1:0] gpio_out,
	output logic [NGPIO-1:0] gpio_oe,
	output logic [NGPIO-1:0] gpio_pu,
	output logic [NGPIO-1:0] gpio_pd
);
	logic [NGPIO-1:0] out_r, out_nxt, oe_r, oe_nxt, pu_r, pu_nxt, pd_r, pd_nxt;

	logic [3:0] usb_bits, smb_bits;

	// Mode to {out, oe, pu, pd}; unknown modes fall back to plain input
	function automatic logic [3:0] mode_bits(input logic [2:0] mode);
		case (mode)
			hbs_pkg::HBS_GP_IN_PD: mode_bits = 4'h1;
			hbs_pkg::HBS_GP_IN_PU: mode_bits = 4'h2;
			hbs_pkg::HBS_GP_OUT_LO: mode_bits = 4'h4;
			hbs_pkg::HBS_GP_OUT_HI: mode_bits = 4'hc;
			default: mode_bits = 4'h0;
		endcase
	endfunction : mode_bits

	always_comb begin
		usb_bits = mode_bits(usb_mode);
		smb_bits = mode_bits(smb_mode);
		out_nxt = out_r;
		oe_nxt = oe_r;
		pu_nxt = pu_r;
		pd_nxt = pd_r;
		// SMBus applied last so it wins a same-pin collision
		if (usb_wr && int'(usb_idx) < NGPIO) begin
			out_nxt[usb_idx] = usb_bits[3];
			oe_nxt[usb_idx] = usb_bits[2];
			pu_nxt[usb_idx] = usb_bits[1];
			pd_nxt[usb_idx] = usb_bits[0];
		end
		if (smb_wr && smb_en && int'(smb_idx) < NGPIO) begin
			out_nxt[smb_idx] = smb_bits[3];
			oe_nxt[smb_idx] = smb_bits[2];
			pu_nxt[smb_idx] = smb_bits[1];
			pd_nxt[smb_idx] = smb_bits[0];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_r <= '0;
			oe_r <= '0;
			pu_r <= '0;
			pd_r <= '0;
		end else begin
			out_r <= out_nxt;
			oe_r <= oe_nxt;
			pu_r <= pu_nxt;
			pd_r <= pd_nxt;
		end
	end

	assign gpio_out = out_r;
	assign gpio_oe = oe_r;
	assign gpio_pu = pu_r;
	assign gpio_pd = pd_r;
endmodule : hbs_gpio

/* design/hbs_seq.sv */
// Hub boot sequencer: standby, SPI probe, strap load, SMBus detect
`timescale 1ns/10ps
`include "hbs_regs.svh"
// How it works
// - High positive-line strap disables that D+ line
// - High negative-line strap disables that D- line
// - Port disabled only when both straps high
// - USB 2.0 disable also disables SuperSpeed port
// - Fixed-port strap code maps to port prefix
// - Charge strap code maps to port prefix
// - Pins: input, pull-down, pull-up, drive low/high
// - Pin modes written over SMBus or USB
// - Reset low: standby, ports high-Z, PLL halted
// - Standby disables all ports, sets high-Z, clears the other registers
// - Reset high: walk the boot stages
// - Init: start PLL, load defaults, then probe
// - SPI strap: match signature, run external ROM
// - No signature or no strap: default load
// - Default load, then strap values override
// - Slave setting: pull-ups on both pins to SoC
// - 200k pull-up boot code means slave setting
// - SoC stage ends only on register 0xff write
module hbs_seq #(
	parameter int NGPIO = 8,
	parameter int GIW = 3
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pll_locked,
	input wire logic spi_mode_strap,
	input wire logic [5:0] port_pos_line_disable,
	input wire logic [5:0] port_neg_line_disable,
	input wire logic [2:0] fixed_port_strap,
	input wire logic [2:0] charge_port_strap,
	input wire logic [2:0] boot_strap,
	input wire logic smbus_data_pin,
	input wire logic smbus_clock_pin,
	input wire logic flash_rd_valid,
	input wire logic [7:0] flash_rd_data,
	input wire logic soc_wr_en,
	input wire logic [7:0] soc_wr_addr,
	input wire logic smb_gpio_wr,
	input wire logic [GIW-1:0] smb_gpio_idx,
	input wire logic [2:0] smb_gpio_mode,
	input wire logic usb_gpio_wr,
	input wire logic [GIW-1:0] usb_gpio_idx,
	input wire logic [2:0] usb_gpio_mode,
	output hbs_pkg::hbs_stage_t stage,
	output logic pll_run,
	output logic port_hiz,
	output logic flash_rd_req,
	output logic [15:0] flash_rd_addr,
	output logic ext_rom_en,
	output logic [5:0] pos_line_off,
	output logic [5:0] neg_line_off,
	output logic [5:0] port_off,
	output logic [5:0] ss_port_off,
	output logic [5:0] fixed_ports,
	output logic [5:0] charge_ports,
	output logic speed_ind_en,
	output logic smbus_slave_en,
	output logic config_done,
	output logic [NGPIO-1:0] gpio_out,
	output logic [NGPIO-1:0] gpio_oe,
	output logic [NGPIO-1:0] gpio_pu,
	output logic [NGPIO-1:0] gpio_pd
);
	localparam logic [15:0] SPI_WAIT_C = 16'(`HBS_SPI_WAIT_NS / `HBS_CLK_NS);

	hbs_pkg::hbs_stage_t stage_r, stage_nxt;
	logic [1:0] idx_r, idx_nxt;
	logic [15:0] wait_r, wait_nxt;
	logic step_r, step_nxt;
	logic req_r, req_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic ext_r, ext_nxt, pll_r, pll_nxt, done_r, done_nxt;
	logic spd_r, spd_nxt, slv_r, slv_nxt;
	logic load_def, load_strap;
	logic [5:0] pos_r, pos_nxt, neg_r, neg_nxt, off_r, off_nxt, ss_r, ss_nxt;
	logic [5:0] fix_r, fix_nxt, chg_r, chg_nxt;
	logic hiz_r, hiz_nxt;
	logic [5:0] d_pos, d_neg, d_off, d_ss, d_fix, d_chg;

	function automatic logic [7:0] sig_byte(input logic [1:0] i);
		logic [31:0] w;
		w = `HBS_SIG_WORD;
		case (i)
			2'h0: sig_byte = w[31:24];
			2'h1: sig_byte = w[23:16];
			2'h2: sig_byte = w[15:8];
			default: sig_byte = w[7:0];
		endcase
	endfunction : sig_byte

	hbs_strap_decode u_dec (
		.pos_strap(port_pos_line_disable),
		.neg_strap(port_neg_line_disable),
		.fixed_code(fixed_port_strap),
		.charge_code(charge_port_strap),
		.pos_off(d_pos),
		.neg_off(d_neg),
		.port_off(d_off),
		.ss_off(d_ss),
		.fixed_mask(d_fix),
		.charge_mask(d_chg)
	);

	hbs_gpio #(.NGPIO(NGPIO), .IW(GIW)) u_gpio (
		.clk(clk),
		.reset_n(reset_n),
		.smb_en(slv_r),
		.smb_wr(smb_gpio_wr),
		.smb_idx(smb_gpio_idx),
		.smb_mode(smb_gpio_mode),
		.usb_wr(usb_gpio_wr),
		.usb_idx(usb_gpio_idx),
		.usb_mode(usb_gpio_mode),
		.gpio_out(gpio_out),
		.gpio_oe(gpio_oe),
		.gpio_pu(gpio_pu),
		.gpio_pd(gpio_pd)
	);

	// Stage sequencing
	always_comb begin
		stage_nxt = stage_r;
		idx_nxt = idx_r;
		wait_nxt = wait_r;
		step_nxt = step_r;
		req_nxt = req_r;
		addr_nxt = addr_r;
		ext_nxt = ext_r;
		pll_nxt = pll_r;
		done_nxt = done_r;
		spd_nxt = spd_r;
		slv_nxt = slv_r;
		load_def = 1'b0;
		load_strap = 1'b0;
		case (stage_r)
			hbs_pkg::HBS_INIT: begin
				pll_nxt = 1'b1;
				if (pll_locked) begin
					load_def = 1'b1;
					idx_nxt = 2'h0;
					wait_nxt = 16'h0000;
					step_nxt = 1'b0;
					stage_nxt = spi_mode_strap ? hbs_pkg::HBS_SPI_RD : hbs_pkg::HBS_CFG_RD;
				end
			end
			hbs_pkg::HBS_SPI_RD: begin
				req_nxt = 1'b1;
				addr_nxt = 16'(`HBS_SIG_ADDR + {14'h0000, idx_r});
				wait_nxt = wait_r + 16'h0001;
				if (req_r && flash_rd_valid) begin
					req_nxt = 1'b0;
					wait_nxt = 16'h0000;
					if (flash_rd_data != sig_byte(idx_r)) begin
						stage_nxt = hbs_pkg::HBS_CFG_RD;
					end else if (idx_r == `HBS_SIG_LAST) begin
						ext_nxt = 1'b1;
						addr_nxt = `HBS_EXEC_ADDR;
						stage_nxt = hbs_pkg::HBS_EXT_RUN;
					end else begin
						idx_nxt = idx_r + 2'h1;
					end
				end else if (wait_r >= SPI_WAIT_C) begin
					// Silent flash counts as absent
					req_nxt = 1'b0;
					stage_nxt = hbs_pkg::HBS_CFG_RD;
				end
			end
			hbs_pkg::HBS_CFG_RD: begin
				step_nxt = 1'b1;
				if (!step_r) begin
					load_def = 1'b1;
				end else begin
					load_strap = 1'b1;
					stage_nxt = hbs_pkg::HBS_STRAP;
				end
			end
			hbs_pkg::HBS_STRAP: begin
				if (boot_strap == `HBS_R200K_PU) begin
					spd_nxt = 1'b1;
					if (smbus_data_pin && smbus_clock_pin) begin
						slv_nxt = 1'b1;
						stage_nxt = hbs_pkg::HBS_SOC_CFG;
					end else begin
						stage_nxt = hbs_pkg::HBS_OTP_CFG;
					end
				end else begin
					stage_nxt = hbs_pkg::HBS_OTP_CFG;
				end
			end
			hbs_pkg::HBS_SOC_CFG: begin
				// No timeout: the SoC may take as long as it likes
				if (soc_wr_en && soc_wr_addr == `HBS_SOC_END_REG)
					stage_nxt = hbs_pkg::HBS_OTP_CFG;
			end
			hbs_pkg::HBS_OTP_CFG: begin
				done_nxt = 1'b1;
			end
			hbs_pkg::HBS_EXT_RUN: begin
				ext_nxt = 1'b1;
			end
			default: begin
				stage_nxt = hbs_pkg::HBS_INIT;
			end
		endcase
	end

	// Reset low is standby; every stage is dropped at once
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage_r <= hbs_pkg::HBS_INIT;
			idx_r <= 2'h0;
			wait_r <= 16'h0000;
			step_r <= 1'b0;
			req_r <= 1'b0;
			addr_r <= 16'h0000;
			ext_r <= 1'b0;
			pll_r <= 1'b0;
			done_r <= 1'b0;
			spd_r <= 1'b0;
			slv_r <= 1'b0;
		end else begin
			stage_r <= stage_nxt;
			idx_r <= idx_nxt;
			wait_r <= wait_nxt;
			step_r <= step_nxt;
			req_r <= req_nxt;
			addr_r <= addr_nxt;
			ext_r <= ext_nxt;
			pll_r <= pll_nxt;
			done_r <= done_nxt;
			spd_r <= spd_nxt;
			slv_r <= slv_nxt;
		end
	end

	// Port configuration
	always_comb begin
		pos_nxt = pos_r;
		neg_nxt = neg_r;
		off_nxt = off_r;
		ss_nxt = ss_r;
		fix_nxt = fix_r;
		chg_nxt = chg_r;
		hiz_nxt = hiz_r;
		if (load_def) begin
			pos_nxt = `HBS_DEF_OFF;
			neg_nxt = `HBS_DEF_OFF;
			off_nxt = `HBS_DEF_OFF;
			ss_nxt = `HBS_DEF_OFF;
			fix_nxt = `HBS_DEF_FIXED;
			chg_nxt = `HBS_DEF_CHARGE;
		end
		if (load_strap) begin
			pos_nxt = d_pos;
			neg_nxt = d_neg;
			off_nxt = d_off;
			ss_nxt = d_ss;
			fix_nxt = d_fix;
			chg_nxt = d_chg;
		end
		if (stage_r == hbs_pkg::HBS_OTP_CFG)
			hiz_nxt = 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pos_r <= `HBS_STBY_OFF;
			neg_r <= `HBS_STBY_OFF;
			off_r <= `HBS_STBY_OFF;
			ss_r <= `HBS_STBY_OFF;
			fix_r <= `HBS_DEF_FIXED;
			chg_r <= `HBS_DEF_CHARGE;
			hiz_r <= 1'b1;
		end else begin
			pos_r <= pos_nxt;
			neg_r <= neg_nxt;
			off_r <= off_nxt;
			ss_r <= ss_nxt;
			fix_r <= fix_nxt;
			chg_r <= chg_nxt;
			hiz_r <= hiz_nxt;
		end
	end

	assign stage = stage_r;
	assign pll_run = pll_r;
	assign port_hiz = hiz_r;
	assign flash_rd_req = req_r;
	assign flash_rd_addr = addr_r;
	assign ext_rom_en = ext_r;
	assign pos_line_off = pos_r;
	assign neg_line_off = neg_r;
	assign port_off = off_r;
	assign ss_port_off = ss_r;
	assign fixed_ports = fix_r;
	assign charge_ports = chg_r;
	assign speed_ind_en = spd_r;
	assign smbus_slave_en = slv_r;
	assign config_done = done_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	strap_port_off_a: assert property (load_strap |=>
		off_r == ($past(port_pos_line_disable) & $past(port_neg_line_disable))
		&& ss_r == off_r && pos_r == $past(port_pos_line_disable)
		&& neg_r == $past(port_neg_line_disable))
		else $error("port disable does not match straps");
	fixed_mask_a: assert property (load_strap && fixed_port_strap == `HBS_R10_PD |=> fix_r == 6'h0f)
		else $error("fixed port mask wrong");
	charge_mask_a: assert property (load_strap && charge_port_strap == `HBS_R200K_PU |=> chg_r == 6'h01)
		else $error("charge port mask wrong");
	init_pll_a: assert property (stage_r == hbs_pkg::HBS_INIT && pll_locked |=> pll_r && stage_r != hbs_pkg::HBS_INIT)
		else $error("init did not start pll or advance");
	sig_read_a: assert property (stage_r == hbs_pkg::HBS_SPI_RD && req_r |-> addr_r == 16'(`HBS_SIG_ADDR + {14'h0000, idx_r}))
		else $error("signature read address wrong");
	sig_match_a: assert property (stage_r == hbs_pkg::HBS_SPI_RD && req_r && flash_rd_valid && idx_r == 2'h3 && flash_rd_data == 8'h55 |=> ext_r && addr_r == `HBS_EXEC_ADDR)
		else $error("external rom not enabled after signature");
	no_spi_a: assert property (stage_r == hbs_pkg::HBS_INIT && pll_locked && !spi_mode_strap |=> stage_r == hbs_pkg::HBS_CFG_RD ##2 stage_r == hbs_pkg::HBS_STRAP)
		else $error("no spi strap did not reach default load");
	smb_detect_a: assert property (stage_r == hbs_pkg::HBS_STRAP && boot_strap == `HBS_R200K_PU && smbus_data_pin && smbus_clock_pin |=> stage_r == hbs_pkg::HBS_SOC_CFG && spd_r && slv_r)
		else $error("smbus slave not entered");
	other_boot_a: assert property (stage_r == hbs_pkg::HBS_STRAP && boot_strap != `HBS_R200K_PU |=> stage_r == hbs_pkg::HBS_OTP_CFG && !slv_r)
		else $error("non-slave boot setting did not skip to otp");
	soc_hold_a: assert property (stage_r == hbs_pkg::HBS_SOC_CFG && !(soc_wr_en && soc_wr_addr == `HBS_SOC_END_REG) |=> stage_r == hbs_pkg::HBS_SOC_CFG)
		else $error("soc stage left without end write");
	hiz_live_a: assert property (stage_r != hbs_pkg::HBS_OTP_CFG && $past(stage_r) != hbs_pkg::HBS_OTP_CFG |-> hiz_r)
		else $error("ports left high impedance early");
	cover_ext_c: cover property (stage_r == hbs_pkg::HBS_EXT_RUN);
	cover_soc_c: cover property (stage_r == hbs_pkg::HBS_SOC_CFG ##[1:20] stage_r == hbs_pkg::HBS_OTP_CFG);
	cover_otp_c: cover property (stage_r == hbs_pkg::HBS_STRAP ##1 stage_r == hbs_pkg::HBS_OTP_CFG);
	cover_timeout_c: cover property (stage_r == hbs_pkg::HBS_SPI_RD && wait_r >= SPI_WAIT_C);
endmodule : hbs_seq

/* test/hbs_flash_model.sv */
// Behavioural SPI flash that answers byte reads of the firmware signature
`timescale 1ns/10ps
module hbs_flash_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic flash_rd_req,
	input wire logic [15:0] flash_rd_addr,
	input wire logic [7:0] dly,
	input wire logic bad,
	output logic flash_rd_valid,
	output logic [7:0] flash_rd_data
);
	logic [7:0] cnt;
	logic [7:0] rom_byte;
	always_comb begin
		case (flash_rd_addr)
			16'hfffa: rom_byte = 8'h32;
			16'hfffb: rom_byte = 8'h44;
			16'hfffc: rom_byte = 8'h46;
			16'hfffd: rom_byte = bad ? 8'h54 : 8'h55; // Corrupt last byte on demand
			default: rom_byte = 8'hff;
		endcase
	end
	// Slow answers come after dly idle cycles; one byte per request
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 8'h00;
			flash_rd_valid <= 1'b0;
			flash_rd_data <= 8'h5a;
		end else if (flash_rd_valid || !flash_rd_req) begin
			cnt <= 8'h00;
			flash_rd_valid <= 1'b0;
			flash_rd_data <= ~flash_rd_data; // Stale data never lingers
		end else if (cnt == dly) begin
			cnt <= 8'h00;
			flash_rd_valid <= 1'b1;
			flash_rd_data <= rom_byte;
		end else begin
			cnt <= cnt + 8'h01;
			flash_rd_data <= ~flash_rd_data;
		end
	end
endmodule : hbs_flash_model

/* test/hbs_seq_tb_top.sv */
// Self-checking bench for the hub boot sequencer
`timescale 1ns/10ps
module hbs_seq_tb_top;
	logic clk = 1'b0, reset_n = 1'b0, pll_locked = 1'b0, spi_mode_strap = 1'b0;
	logic smbus_data_pin = 1'b1, smbus_clock_pin = 1'b1, soc_wr_en = 1'b0, bad = 1'b0;
	logic smb_gpio_wr = 1'b0, usb_gpio_wr = 1'b0;
	logic [5:0] port_pos_line_disable = 6'h00, port_neg_line_disable = 6'h00;
	logic [2:0] fixed_port_strap = 3'h0, charge_port_strap = 3'h0, boot_strap = 3'h0;
	logic [2:0] smb_gpio_idx = 3'h0, smb_gpio_mode = 3'h0;
	logic [2:0] usb_gpio_idx = 3'h0, usb_gpio_mode = 3'h0;
	logic [7:0] soc_wr_addr = 8'h00, dly = 8'h00;
	hbs_pkg::hbs_stage_t stage;
	logic pll_run, port_hiz, flash_rd_req, ext_rom_en, speed_ind_en, smbus_slave_en;
	logic config_done, flash_rd_valid;
	logic [15:0] flash_rd_addr;
	logic [7:0] flash_rd_data, gpio_out, gpio_oe, gpio_pu, gpio_pd;
	logic [5:0] pos_line_off, neg_line_off, port_off, ss_port_off, fixed_ports, charge_ports;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;

	hbs_seq u_hbs_seq (.clk, .reset_n, .pll_locked, .spi_mode_strap, .port_pos_line_disable,
		.port_neg_line_disable, .fixed_port_strap, .charge_port_strap, .boot_strap,
		.smbus_data_pin, .smbus_clock_pin, .flash_rd_valid, .flash_rd_data, .soc_wr_en,
		.soc_wr_addr, .smb_gpio_wr, .smb_gpio_idx, .smb_gpio_mode, .usb_gpio_wr,
		.usb_gpio_idx, .usb_gpio_mode, .stage, .pll_run, .port_hiz, .flash_rd_req,
		.flash_rd_addr, .ext_rom_en, .pos_line_off, .neg_line_off, .port_off, .ss_port_off,
		.fixed_ports, .charge_ports, .speed_ind_en, .smbus_slave_en, .config_done,
		.gpio_out, .gpio_oe, .gpio_pu, .gpio_pd);
	hbs_flash_model u_hbs_flash_model (.clk, .reset_n, .flash_rd_req, .flash_rd_addr, .dly,
		.bad, .flash_rd_valid, .flash_rd_data);

	always #5 clk = ~clk;

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	// Whole run needs well under 2000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tk

	function automatic logic [5:0] pm(input int c);
		return c == 5 ? 6'h3f : 6'((1 << c) - 1);
	endfunction : pm

	task automatic boot(input logic sp, input logic [2:0] bc, input logic [1:0] pins);
		@(posedge clk);
		reset_n <= 1'b0;
		pll_locked <= 1'b0;
		spi_mode_strap <= sp;
		boot_strap <= bc;
		{smbus_data_pin, smbus_clock_pin} <= pins;
		tk(10);
		chk("stage_rst", 16'h0000, stage);
		chk("hiz_rst", 16'h0001, port_hiz);
		chk("pll_rst", 16'h0000, pll_run);
		chk("off_rst", 16'h003f, port_off);
		chk("gpio_rst", 16'h0000, gpio_oe | gpio_pu | gpio_pd | gpio_out);
		@(posedge clk);
		reset_n <= 1'b1;
		tk(3);
		chk("pll_on", 16'h0001, pll_run);
		chk("wait_lock", 16'h0000, stage);
		@(posedge clk);
		pll_locked <= 1'b1;
	endtask : boot

	task automatic wst(input hbs_pkg::hbs_stage_t s, input string nm);
		int n;
		n = 0;
		while (stage !== s && n < 800) begin
			tk(1);
			n++;
		end
		chk(nm, s, stage);
	endtask : wst

	task automatic gw(input logic s, input logic u, input logic [2:0] i, input logic [2:0] m);
		@(posedge clk);
		smb_gpio_wr <= s;
		usb_gpio_wr <= u;
		smb_gpio_idx <= i;
		usb_gpio_idx <= i;
		smb_gpio_mode <= m;
		usb_gpio_mode <= s ? 3'h3 : m;
		@(posedge clk);
		smb_gpio_wr <= 1'b0;
		usb_gpio_wr <= 1'b0;
		tk(1);
	endtask : gw

	task automatic sw(input logic [7:0] a);
		@(posedge clk);
		soc_wr_en <= 1'b1;
		soc_wr_addr <= a;
		@(posedge clk);
		soc_wr_en <= 1'b0;
		#1;
	endtask : sw

	task automatic t_straps();
		logic [5:0] p;
		for (int c = 0; c < 6; c++) begin
			p = 6'h15 ^ 6'(c);
			@(posedge clk);
			port_pos_line_disable <= p;
			port_neg_line_disable <= 6'h33;
			fixed_port_strap <= 3'(c);
			charge_port_strap <= 3'(5 - c);
			boot(1'b0, 3'h0, 2'h3);
			wst(hbs_pkg::HBS_OTP_CFG, "stage_otp");
			chk("pos_off", p, pos_line_off);
			chk("neg_off", 16'h0033, neg_line_off);
			chk("port_off", p & 6'h33, port_off);
			chk("ss_off", p & 6'h33, ss_port_off);
			chk("fixed", pm(c), fixed_ports);
			chk("charge", pm(5 - c), charge_ports);
			chk("slave", 16'h0000, smbus_slave_en);
		end
		$display("straps done");
	endtask : t_straps

	task automatic t_soc();
		boot(1'b0, 3'h1, 2'h3);
		wst(hbs_pkg::HBS_SOC_CFG, "stage_soc");
		chk("speed_ind", 16'h0001, speed_ind_en);
		chk("slave_on", 16'h0001, smbus_slave_en);
		gw(1'b1, 1'b1, 3'h5, 3'h4);
		chk("smb_wins", 16'h0001, gpio_out[5] & gpio_oe[5]);
		sw(8'hfe);
		tk(3);
		chk("stay_soc", hbs_pkg::HBS_SOC_CFG, stage);
		sw(8'hff);
		chk("soc_end", hbs_pkg::HBS_OTP_CFG, stage);
		tk(1);
		chk("cfg_done", 16'h0001, config_done);
		chk("hiz_off", 16'h0000, port_hiz);
		$display("soc done");
	endtask : t_soc

	task automatic t_other();
		logic [2:0] codes [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
		foreach (codes[k]) begin
			boot(1'b0, codes[k], 2'h3);
			wst(hbs_pkg::HBS_OTP_CFG, "skip_soc");
			chk("no_slave", 16'h0000, smbus_slave_en | speed_ind_en);
		end
		for (int k = 1; k < 3; k++) begin
			boot(1'b0, 3'h1, 2'(k));
			wst(hbs_pkg::HBS_OTP_CFG, "one_pull");
			chk("no_slave1", 16'h0000, smbus_slave_en);
			chk("speed_ind1", 16'h0001, speed_ind_en);
			gw(1'b1, 1'b0, 3'h2, 3'h4);
			chk("smb_ignored", 16'h0000, gpio_oe[2]);
		end
		$display("other codes done");
	endtask : t_other

	task automatic t_spi();
		int n;
		// Pass 2: flash too slow, the probe must time out
		for (int b = 0; b < 3; b++) begin
			@(posedge clk);
			bad <= (b == 1);
			dly <= (b == 2) ? 8'hff : 8'(b * 5);
			boot(1'b1, 3'h0, 2'h3);
			n = 0;
			while (flash_rd_req !== 1'b1 && n < 50) begin
				tk(1);
				n++;
			end
			chk("req_on", 16'h0001, flash_rd_req);
			chk("sig_addr", 16'hfffa, flash_rd_addr);
			if (b == 0) begin
				wst(hbs_pkg::HBS_EXT_RUN, "ext_run");
				chk("exec_addr", 16'h0000, flash_rd_addr);
			end else begin
				wst(hbs_pkg::HBS_OTP_CFG, "no_sig");
			end
			chk("ext_en", (b == 0) ? 16'h0001 : 16'h0000, ext_rom_en);
			chk("req_off", 16'h0000, flash_rd_req);
		end
		$display("spi done");
	endtask : t_spi

	task automatic t_gpio();
		logic [3:0] tbl [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hc};
		for (int m = 0; m < 5; m++) begin
			gw(1'b0, 1'b1, 3'(m), 3'(m));
			chk("pin_mode", tbl[m], {gpio_out[m], gpio_oe[m], gpio_pu[m], gpio_pd[m]});
		end
		gw(1'b0, 1'b1, 3'h7, 3'h4);
		gw(1'b0, 1'b1, 3'h7, 3'h7);
		chk("bad_mode", 16'h0000, {gpio_out[7], gpio_oe[7], gpio_pu[7], gpio_pd[7]});
		$display("gpio done");
	endtask : t_gpio

	task automatic t_abort();
		boot(1'b0, 3'h1, 2'h3);
		wst(hbs_pkg::HBS_SOC_CFG, "abort_soc");
		gw(1'b0, 1'b1, 3'h1, 3'h4);
		chk("pre_abort", 16'h0001, gpio_oe[1]);
		@(posedge clk);
		reset_n <= 1'b0;
		#2;
		chk("abort_stage", 16'h0000, stage);
		chk("abort_gpio", 16'h0000, gpio_oe);
		chk("abort_off", 16'h003f, ss_port_off);
		chk("abort_pll", 16'h0000, pll_run);
		$display("abort done");
	endtask : t_abort

	initial begin
		t_straps();
		t_soc();
		t_other();
		t_spi();
		t_gpio();
		t_abort();
		wrap_up();
	end
endmodule : hbs_seq_tb_top
